// ### mtsc_top.sv
// Travel stop protection block with AXI4-Lite registers
//
// Behaviour
// - Limit monitoring on: either limit input raises fault or alarm, solenoid/actuator only.
// - Torque monitoring on: either torque input raises fault or alarm, solenoid/actuator only.
// - Stop at travel end set: block rotation toward the reached limit.
// - Stop at travel end clear: rotation toward a reached limit stays allowed.
// - Actuator with stop at torque set: block rotation toward the tripped torque switch.
// - Stop at torque clear: rotation toward a tripped torque switch stays allowed.
// - Stop at current set: threshold stops motor, then blocks restart that direction.
// - Stop at current clear: rotation continues when the threshold is reached.
// - Per protection fail/alarm select; enable bit zero ignores that protection.
`timescale 1ns/1ps
`include "mtsc_regs.svh"
module mtsc_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Switch pins: bit 0 forward, bit 1 reverse
  input  wire logic [1:0]  limit_in,
  input  wire logic [1:0]  torque_in,
  input  wire logic        current_over_in,
  // Motor command from control logic
  input  wire logic        run_cmd,
  input  wire logic        dir_cmd,
  // Motor drive and protection outputs
  output logic             motor_run_fwd,
  output logic             motor_run_rev,
  output logic             fault_out,
  output logic             alarm_out,
  output logic             irq
);
  mtsc_pkg::mtsc_top_st_t s;
  mtsc_pkg::mtsc_top_st_t next_s;
  logic [4:0]             pins;
  mtsc_guard_if           gif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] strobe_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] strobe_mask(
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic mapped(
    input logic [7:0] a
  );
    return (a == `MTSC_CFG_OFS) || (a == `MTSC_SEL_OFS) || (a == `MTSC_STAT_OFS)
        || (a == `MTSC_MASK_OFS) || (a == `MTSC_LIVE_OFS);
  endfunction

  // Configuration type field, decoded for the guard and the events
  function automatic mtsc_pkg::mtsc_typ_t cfg_type(
    input logic [15:0] c
  );
    return mtsc_pkg::mtsc_typ_t'(c[`MTSC_TYP_LSB +: 2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and direction guard

  // Field pins cross domains; only the second stage is read
  mtsc_sync #(
    .W (5)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({current_over_in, torque_in, limit_in}),
    .dout    (pins)
  );

  // Settings and synchronised pins toward the guard
  assign gif.stop_at_travel_end    = s.cfg[`MTSC_STOP_END_BIT];
  assign gif.stop_at_torque_trip   = s.cfg[`MTSC_STOP_TRQ_BIT];
  assign gif.stop_at_current_level = s.cfg[`MTSC_STOP_CUR_BIT];
  assign gif.actuator    = (cfg_type(s.cfg) == mtsc_pkg::MTSC_TYP_ACTUATOR);
  assign gif.limit_hit    = pins[1:0];
  assign gif.torque_hit   = pins[3:2];
  assign gif.current_over = pins[4];
  assign gif.run_cmd      = run_cmd;
  assign gif.dir_cmd      = dir_cmd;

  mtsc_guard u_guard (
    .aclk    (aclk),
    .aresetn (aresetn),
    .g       (gif.guard)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection evaluation, registers and bus

  always_comb begin
    logic        typ_ok;
    logic        lim_mon;
    logic        trq_mon;
    logic [2:0]  act;
    logic [2:0]  en;
    logic [2:0]  fail;
    logic        flt;
    logic        alm;
    logic [4:0]  cond;
    logic [4:0]  rise;
    logic [31:0] wd;
    logic [31:0] live;
    logic        do_wr;
    mtsc_pkg::mtsc_typ_t typ;

    // Every local starts driven so no path leaves a latch
    typ     = mtsc_pkg::MTSC_TYP_OTHER;
    typ_ok  = 1'b0;
    lim_mon = 1'b0;
    trq_mon = 1'b0;
    act     = '0;
    en      = '0;
    fail    = '0;
    flt     = 1'b0;
    alm     = 1'b0;
    cond    = '0;
    rise    = '0;
    wd      = '0;
    live    = '0;
    do_wr   = 1'b0;
    next_s = s;
    typ = cfg_type(s.cfg);
    typ_ok = (typ == mtsc_pkg::MTSC_TYP_SOLENOID)
          || (typ == mtsc_pkg::MTSC_TYP_ACTUATOR);

    // Monitored switch activity
    lim_mon = s.cfg[`MTSC_LIM_MON_BIT] & typ_ok & (|pins[1:0]);
    trq_mon = s.cfg[`MTSC_TRQ_MON_BIT] & typ_ok & (|pins[3:2]);
    act  = {gif.cur_trip, trq_mon, lim_mon};
    en   = s.sel[`MTSC_EN_LSB +: 3];
    fail = s.sel[`MTSC_FAIL_LSB +: 3];
    // Disabled protections are ignored
    flt = |(act & en & fail);
    alm = |(act & en & ~fail);
    next_s.fault = flt;
    next_s.alarm = alm;

    // Sticky status on rising edge, set wins over clear
    cond = {alm, flt, gif.cur_trip, trq_mon, lim_mon};
    rise = cond & ~s.cond_prev;
    next_s.cond_prev = cond;

    // Write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_done = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_done = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    // Commit once both halves are in and no response is pending
    do_wr = s.aw_done && s.w_done && !s.bvalid;
    next_s.stat = s.stat;
    if (do_wr) begin
      next_s.aw_done = 1'b0;
      next_s.w_done  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = mapped(s.awaddr) ? `MTSC_RESP_OKAY : `MTSC_RESP_SLVERR;
      unique case (s.awaddr)
        `MTSC_CFG_OFS: begin
          wd = strobe_merge({16'h0, s.cfg}, s.wdata, s.wstrb);
          next_s.cfg = wd[15:0];
        end
        `MTSC_SEL_OFS: begin
          wd = strobe_merge({24'h0, s.sel}, s.wdata, s.wstrb);
          next_s.sel = {1'b0, wd[6:4], 1'b0, wd[2:0]};
        end
        `MTSC_STAT_OFS: begin
          wd = s.wdata & strobe_mask(s.wstrb);
          next_s.stat = s.stat & ~wd[4:0];
        end
        `MTSC_MASK_OFS: begin
          wd = strobe_merge({27'h0, s.mask}, s.wdata, s.wstrb);
          next_s.mask = wd[4:0];
        end
        default: begin
          wd = '0;
        end
      endcase
    end else begin
      wd = '0;
    end
    // Set wins: a clear in the same cycle cannot hide a new event
    next_s.stat = next_s.stat | rise;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Read channel
    // Live view: remembered blocks, drive and protection outputs
    live = {24'h0,
            gif.cur_block,
            gif.run_rev, gif.run_fwd,
            2'h0,
            s.alarm, s.fault};
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = mapped(s_axi_araddr) ? `MTSC_RESP_OKAY : `MTSC_RESP_SLVERR;
      unique case (s_axi_araddr)
        `MTSC_CFG_OFS: begin
          next_s.rdata = {16'h0, s.cfg};
        end
        `MTSC_SEL_OFS: begin
          next_s.rdata = {24'h0, s.sel};
        end
        `MTSC_STAT_OFS: begin
          next_s.rdata = {27'h0, s.stat};
        end
        `MTSC_MASK_OFS: begin
          next_s.rdata = {27'h0, s.mask};
        end
        `MTSC_LIVE_OFS: begin
          next_s.rdata = live;
        end
        default: begin
          next_s.rdata = '0;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    next_s.irq = |(next_s.stat & s.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Clear everything, then load the register defaults
      s      <= '0;
      s.cfg  <= `MTSC_CFG_RST;
      s.sel  <= `MTSC_SEL_RST;
      s.mask <= `MTSC_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Ready stays low while a response waits: one write at a time
  assign s_axi_awready = !s.aw_done && !s.bvalid;
  assign s_axi_wready  = !s.w_done && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;

  // Read address refused until the data is taken
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // Motor drive and protection levels
  assign motor_run_fwd = gif.run_fwd;
  assign motor_run_rev = gif.run_rev;
  assign fault_out     = s.fault;
  assign alarm_out     = s.alarm;
  assign irq           = s.irq;
endmodule

// ### mtsc_regs.svh
// Register offsets, field positions and reset values of the travel stop block
`ifndef MTSC_REGS_SVH
`define MTSC_REGS_SVH
`define MTSC_CFG_OFS      8'h00
`define MTSC_SEL_OFS      8'h04
`define MTSC_STAT_OFS     8'h08
`define MTSC_MASK_OFS     8'h0c
`define MTSC_LIVE_OFS     8'h10
`define MTSC_TYP_LSB      0
`define MTSC_LIM_MON_BIT  11
`define MTSC_TRQ_MON_BIT  12
`define MTSC_STOP_END_BIT 13
`define MTSC_STOP_TRQ_BIT 14
`define MTSC_STOP_CUR_BIT 15
`define MTSC_FAIL_LSB     0
`define MTSC_EN_LSB       4
`define MTSC_CFG_RST      16'h0000
`define MTSC_SEL_RST      8'h70
`define MTSC_MASK_RST     5'h00
`define MTSC_ST_LIM       0
`define MTSC_ST_TRQ       1
`define MTSC_ST_CUR       2
`define MTSC_ST_FLT       3
`define MTSC_ST_ALM       4
`define MTSC_RESP_OKAY    2'h0
`define MTSC_RESP_SLVERR  2'h2
`endif

// ### mtsc_pkg.sv
// Types of the travel stop block
package mtsc_pkg;
  typedef enum logic [1:0] {
    MTSC_TYP_OTHER,
    MTSC_TYP_SOLENOID,
    MTSC_TYP_ACTUATOR,
    MTSC_TYP_SPARE
  } mtsc_typ_t;

  typedef struct packed {
    logic       aw_done;
    logic       w_done;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] cfg;
    logic [7:0] sel;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [4:0] cond_prev;
    logic       fault;
    logic       alarm;
    logic       irq;
  } mtsc_top_st_t;

  typedef struct packed {
    logic [1:0] cur_block;
    logic       run_fwd;
    logic       run_rev;
    logic       cur_trip;
  } mtsc_guard_st_t;
endpackage

// ### mtsc_guard_if.sv
// Signals between the register side and the direction guard
`timescale 1ns/1ps
interface mtsc_guard_if;
  logic       stop_at_travel_end;
  logic       stop_at_torque_trip;
  logic       stop_at_current_level;
  logic       actuator;
  logic [1:0] limit_hit;
  logic [1:0] torque_hit;
  logic       current_over;
  logic       run_cmd;
  logic       dir_cmd;
  logic       run_fwd;
  logic       run_rev;
  logic [1:0] cur_block;
  logic       cur_trip;
  modport ctl (
    output stop_at_travel_end, stop_at_torque_trip, stop_at_current_level,
    output actuator, limit_hit, torque_hit, current_over, run_cmd, dir_cmd,
    input  run_fwd, run_rev, cur_block, cur_trip
  );
  modport guard (
    input  stop_at_travel_end, stop_at_torque_trip, stop_at_current_level,
    input  actuator, limit_hit, torque_hit, current_over, run_cmd, dir_cmd,
    output run_fwd, run_rev, cur_block, cur_trip
  );
endinterface

// ### mtsc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mtsc_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pins and synchronised levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [2*W-1:0] st;
  logic [2*W-1:0] next_st;

  always_comb begin
    next_st = {st[W-1:0], din};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st[2*W-1:W];
endmodule

// ### mtsc_guard.sv
// Direction guard: blocks motor rotation toward a reached stop
`timescale 1ns/1ps
module mtsc_guard (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Block side
  mtsc_guard_if.guard g
);
  mtsc_pkg::mtsc_guard_st_t s;
  mtsc_pkg::mtsc_guard_st_t next_s;

  always_comb begin
    logic       want_f;
    logic       want_r;
    logic [1:0] trip;
    logic [1:0] blk;
    want_f = g.run_cmd & ~g.dir_cmd;
    want_r = g.run_cmd & g.dir_cmd;
    next_s = s;
    // Threshold stops the motor in its running direction
    trip = {s.run_rev, s.run_fwd} & {2{g.stop_at_current_level & g.current_over}};
    blk = ({2{g.stop_at_travel_end}} & g.limit_hit)
        | ({2{g.stop_at_torque_trip & g.actuator}} & g.torque_hit)
        | s.cur_block | trip;
    next_s.cur_block = s.cur_block | trip;
    // Opposite rotation releases the remembered direction
    if (s.run_rev) begin
      next_s.cur_block[0] = trip[0];
    end
    if (s.run_fwd) begin
      next_s.cur_block[1] = trip[1];
    end
    if (!g.stop_at_current_level) begin
      next_s.cur_block = 2'h0;
    end
    next_s.run_fwd = want_f & ~blk[0];
    next_s.run_rev = want_r & ~blk[1];
    next_s.cur_trip = |trip;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign g.run_fwd   = s.run_fwd;
  assign g.run_rev   = s.run_rev;
  assign g.cur_block = s.cur_block;
  assign g.cur_trip  = s.cur_trip;
endmodule

// ### mtsc_top_monitor.sv
// Port assertions of the travel stop block
`timescale 1ns/1ps
module mtsc_top_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Field and motor
  input wire logic [1:0]  limit_in,
  input wire logic [1:0]  torque_in,
  input wire logic        run_cmd,
  input wire logic        dir_cmd,
  input wire logic        motor_run_fwd,
  input wire logic        motor_run_rev
);
  logic [15:0] cfg;
  logic        aw_w;
  assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Shadow of the setting word, full-word writes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= 16'h0000;
    end else if (aw_w && s_axi_awaddr == 8'h00 && s_axi_wstrb == 4'hf) begin
      cfg <= s_axi_wdata[15:0];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  one_dir_a: assert property (!(motor_run_fwd && motor_run_rev))
    else $error("motor driven both ways");
  fwd_cause_a: assert property (motor_run_fwd |-> $past(run_cmd) && !$past(dir_cmd))
    else $error("forward drive without forward command");
  rev_cause_a: assert property (motor_run_rev |-> $past(run_cmd) && $past(dir_cmd))
    else $error("reverse drive without reverse command");
  end_block_a: assert property (cfg[13] && $past(cfg[13], 2) && limit_in[0] &&
    $past(limit_in[0]) && $past(limit_in[0], 2) && $past(limit_in[0], 3) |-> !motor_run_fwd)
    else $error("forward drive into reached limit");
  trq_block_a: assert property (cfg[14] && $past(cfg[14], 2) && cfg[1:0] == 2'h2 &&
    torque_in[1] && $past(torque_in[1]) && $past(torque_in[1], 2) &&
    $past(torque_in[1], 3) |-> !motor_run_rev)
    else $error("reverse drive into tripped torque switch");
  b_lat_a: assert property (aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule

// ### mtsc_field.sv
// Field switches and contactor current seen by the travel stop block
`timescale 1ns/1ps
module mtsc_field (
  // Clock
  input  wire logic       aclk,
  // Field state set by the bench
  input  wire logic [1:0] at_end,
  input  wire logic [1:0] at_trq,
  input  wire logic       overload,
  // Contactor
  input  wire logic       motor_run_fwd,
  input  wire logic       motor_run_rev,
  // Switch pins
  output logic      [1:0] limit_in = 2'h0,
  output logic      [1:0] torque_in = 2'h0,
  output logic            current_over_in = 1'b0
);
  // Current only flows while the contactor drives the motor
  always_ff @(posedge aclk) begin
    limit_in        <= at_end;
    torque_in       <= at_trq;
    current_over_in <= overload && (motor_run_fwd || motor_run_rev);
  end
endmodule

// ### motor_travel_stop_config_tb.sv
// Self-checking bench of the travel stop block
`timescale 1ns/1ps
module motor_travel_stop_config_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, run = 1'b0, dir = 1'b0, over = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, cfg = 32'h0, sel = 32'h70, stat = 32'h0, mask = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, lim, trq, at_end = 2'h0, at_trq = 2'h0, mem = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, cur, fwd, rev, flt, alm, irq;
  logic [15:0] lfsr_q = 16'hd0d8;
  int fails = 0, tests_run = 0;
  mtsc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .limit_in(lim),
    .torque_in(trq), .current_over_in(cur), .run_cmd(run), .dir_cmd(dir),
    .motor_run_fwd(fwd), .motor_run_rev(rev), .fault_out(flt), .alarm_out(alm), .irq(irq));
  mtsc_field i_field (.aclk(aclk), .at_end(at_end), .at_trq(at_trq), .overload(over),
    .motor_run_fwd(fwd), .motor_run_rev(rev), .limit_in(lim), .torque_in(trq),
    .current_over_in(cur));
  initial begin
    forever #2 aclk = ~aclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] m_resp(input logic [7:0] a);
    return (a <= 8'h10 && a[1:0] == 2'h0) ? 2'h0 : 2'h2;
  endfunction
  function automatic logic [31:0] m_rd(input logic [7:0] a);
    case (a)
      8'h00: return cfg;
      8'h04: return sel;
      8'h08: return stat;
      8'h0c: return mask;
      8'h10: return {24'h0, mem, m_run(1'b1), m_run(1'b0), 2'h0, m_fa()};
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic m_run(input logic d);
    return run && dir == d && !(cfg[13] && at_end[d]) && !mem[d] &&
      !(cfg[14] && cfg[1:0] == 2'h2 && at_trq[d]);
  endfunction
  function automatic logic [1:0] m_fa;
    logic le, te, ty;
    ty = cfg[1:0] == 2'h1 || cfg[1:0] == 2'h2;
    le = cfg[11] && sel[4] && ty && |at_end;
    te = cfg[12] && sel[5] && ty && |at_trq;
    return {(le && !sel[0]) || (te && !sel[1]), (le && sel[0]) || (te && sel[1])};
  endfunction
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    {ta, tw} = 2'h0;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    chk_word("bresp", {30'h0, m_resp(a)}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'b0;
    case (a)
      8'h00: cfg = {16'h0, d[15:0]};
      8'h04: sel = d & 32'h77;
      8'h08: stat = stat & ~d;
      8'h0c: mask = d & 32'h1f;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk_word("rdata", m_rd(a), rdata);
    chk_word("rresp", {30'h0, m_resp(a)}, {30'h0, rresp});
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic look;
    logic [1:0] fa;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    fa = m_fa();
    chk_pin("run_fwd", m_run(1'b0), fwd);
    chk_pin("run_rev", m_run(1'b1), rev);
    chk_pin("fault", fa[0], flt);
    chk_pin("alarm", fa[1], alm);
    @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rd(8'(a));
    wr(8'h20, 32'h1);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      wr(8'h00, {lfsr_q, lfsr_q});
      rd(8'h00);
      wr(8'h04, {24'h0, lfsr_q[7:0]});
      rd(8'h04);
    end
    $display("Test registers done");
    wr(8'h04, 32'h71);
    wr(8'h00, 32'h2802);
    run <= 1'b1;
    at_end <= 2'h1;
    look;
    stat = stat | 32'h09;
    dir <= 1'b1;
    look;
    dir <= 1'b0;
    wr(8'h00, 32'h0802);
    look;
    wr(8'h00, 32'h0800);
    look;
    wr(8'h04, 32'h61);
    wr(8'h00, 32'h0802);
    look;
    at_end <= 2'h0;
    $display("Test limit done");
    wr(8'h04, 32'h30);
    wr(8'h00, 32'h5002);
    at_trq <= 2'h2;
    dir <= 1'b1;
    look;
    stat = stat | 32'h12;
    wr(8'h00, 32'h5001);
    look;
    wr(8'h00, 32'h1002);
    look;
    at_trq <= 2'h0;
    $display("Test torque done");
    wr(8'h00, 32'h8002);
    dir <= 1'b0;
    look;
    over <= 1'b1;
    mem = 2'h1;
    stat = stat | 32'h04;
    look;
    over <= 1'b0;
    look;
    rd(8'h10);
    dir <= 1'b1;
    look;
    mem = 2'h0;
    dir <= 1'b0;
    look;
    wr(8'h00, 32'h0002);
    over <= 1'b1;
    look;
    over <= 1'b0;
    $display("Test current done");
    rd(8'h08);
    @(negedge aclk);
    chk_pin("irq", 1'b0, irq);
    wr(8'h0c, 32'h04);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_pin("irq", 1'b1, irq);
    wr(8'h08, 32'h04);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_pin("irq", 1'b0, irq);
    rd(8'h08);
    rd(8'h0c);
    $display("Test interrupt done");
    complete_run;
  end
endmodule
bind mtsc_top mtsc_top_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .limit_in(limit_in), .torque_in(torque_in), .run_cmd(run_cmd), .dir_cmd(dir_cmd),
  .motor_run_fwd(motor_run_fwd), .motor_run_rev(motor_run_rev));
